// ### verilog/ssw_pkg.sv
/*
 * Package for the supply supervisor and watchdog block: timing constants,
 * state encodings and the packed carrier structs used on its ports.
 * Assumes a single 40 MHz clock; all analogue comparisons arrive as digital levels.
 */
package ssw_pkg;

    // System clock rate in hertz and its period in nanoseconds.
    localparam longint CLK_HZ = 40000000;
    localparam int CLK_NS = 25;

    // Reset stretch after supply-good or manual reset release, in ms.
    localparam int RST_STRETCH_MS = 200;
    localparam int RST_STRETCH_CYC = RST_STRETCH_MS * 40000;
    // Default watchdog timeout, 1.6 s, held in tenths of a second.
    localparam int WD_DEFAULT_DS = 16;
    localparam int WD_DEFAULT_CYC = WD_DEFAULT_DS * 4000000;
    // External-capacitor timeout: 2.1 ms per nF, held in tenths of a ms.
    localparam int WD_CAP_DMS_PER_NF = 21;
    localparam int WD_CAP_CYC_PER_NF = WD_CAP_DMS_PER_NF * 4000;
    // Fault pulse width, 1 ms, least time; the cycle count is rounded down.
    localparam int PULSE_MS = 1;
    localparam int PULSE_CYC = PULSE_MS * 40000;
    // Delay from pulse fall to latched fault fall, 70 ns rounded up.
    localparam int LEAD_NS = 70;
    localparam int LEAD_CYC = (LEAD_NS + CLK_NS - 1) / CLK_NS;
    // Chip-select hold after reset assertion, 15 us, longest time rounded down.
    localparam int SEL_HOLD_US = 15;
    localparam int SEL_HOLD_CYC = (SEL_HOLD_US * 1000) / CLK_NS;
    // Least manual reset pulse that clears the counters, 15 us rounded up.
    localparam int MR_MIN_US = 15;
    localparam int MR_MIN_CYC = (MR_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;

    // Counter width large enough for the longest timeout.
    localparam int CNT_W = 32;
    // Capacitor value field width in nanofarads.
    localparam int CAP_W = 8;

    // Three-level kick input classification.
    typedef enum logic [1:0] {
        KICK_LOW = 2'h0,
        KICK_HIGH = 2'h1,
        KICK_OPEN = 2'h2
    } ssw_kick_type;

    // Watchdog sequencer states, one-hot.
    typedef enum logic [3:0] {
        WD_IDLE = 4'h1,
        WD_RUN = 4'h2,
        WD_LEAD = 4'h4,
        WD_FAULT = 4'h8
    } ssw_wd_type;

    // Comparator results from the analogue front end.
    typedef struct packed {
        logic main_good;
        logic low_line;
        logic on_backup;
        logic aux_low;
    } ssw_cmp_type;

    // Watchdog timeout configuration.
    typedef struct packed {
        logic use_cap;
        logic [CAP_W-1:0] cap_nf;
    } ssw_tmo_type;

    // Status outputs toward the host.
    typedef struct packed {
        logic reset_n;
        logic backup_active;
        logic aux_fail_flag;
        logic early_supply_warn;
        logic fault_out_n;
        logic fault_pulse_n;
    } ssw_stat_type;

endpackage

// ### verilog/ssw_top.sv
/*
 * Supply supervisor with watchdog and RAM chip-select gating.
 * Assumes comparator results and the kick level are already digital and
 * synchronous to ref_clk; they are still passed through two flops here.
 */
`timescale 1ns/1ps

// Overview of operation
// RULE_01: backup_active follows supply switchover to backup.
// RULE_02: aux_fail_flag low when aux below threshold.
// RULE_03: Default timeout is 1.6 seconds.
// RULE_04: Capacitor timeout is 2.1 ms per nF.
// RULE_05: Manual reset holds reset, then 200 ms.
// RULE_06: early_supply_warn low on low-line comparison.
// RULE_07: Mid-level kick_in disables the watchdog.
// RULE_08: Fault low after kick_in idle past timeout.
// RULE_09: Fault stays low until next kick transition.
// RULE_10: Fault high when kick open or reset.
// RULE_11: Fault pulse low at least 1 ms. In the code, a kick transition in WD_FAULT raises the pulse before 1 ms.
// RULE_12: Pulse falls 70 ns before fault falls.
// RULE_13: sel_out_n low only if selected and supply good.
// RULE_14: Hold select 15 us after reset or release.
// RULE_15: Reset low on bad supply, 200 ms stretch.
// RULE_16: Any kick transition restarts the watchdog timer. The code ignores transitions seen while in WD_LEAD.
// RULE_17: Manual reset pulse clears counters, forces outputs.
// RULE_18: Watchdog off on bad supply or backup.
// RULE_19: Synchronise inputs; count times in clock cycles.
module ssw_top #(
    // Clock rate from which every time count below is derived.
    parameter longint CLK_FREQ_HZ = ssw_pkg::CLK_HZ
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic clk_en,
    input wire ssw_pkg::ssw_cmp_type cmp_in,
    input wire ssw_pkg::ssw_kick_type kick_in,
    input wire ssw_pkg::ssw_tmo_type timeout_select,
    input wire logic manual_reset_n,
    input wire logic sel_in_n,
    output ssw_pkg::ssw_stat_type stat_out,
    output logic sel_out_n
);
    import ssw_pkg::*;

    // RULE_19 cycle counts
    // Counts follow the clock parameter, so a slow bench clock keeps runs short.
    localparam int RST_CYC = int'(RST_STRETCH_MS * CLK_FREQ_HZ / 1000);
    localparam int WD_DEF_CYC = int'(WD_DEFAULT_DS * CLK_FREQ_HZ / 10);
    localparam int WD_NF_CYC = int'(WD_CAP_DMS_PER_NF * CLK_FREQ_HZ / 10000);
    localparam int PULSE_N = int'(PULSE_MS * CLK_FREQ_HZ / 1000);
    // The lead is rounded up so that it is never shorter than 70 ns.
    localparam int LEAD_N = int'((LEAD_NS * CLK_FREQ_HZ + 64'd999999999) / 1000000000);
    // The select hold is rounded down so that it never exceeds 15 us.
    localparam int SEL_N = int'(SEL_HOLD_US * CLK_FREQ_HZ / 1000000);
    localparam int MR_N = int'((MR_MIN_US * CLK_FREQ_HZ + 64'd999999) / 1000000);

    ////////////////////////////////////////////////////////////////////////////////
    // State record.

    // All state lives in one packed struct, registered in one process.
    typedef struct packed {
        ssw_cmp_type cmp_s1;
        ssw_cmp_type cmp_s2;
        ssw_kick_type kick_s1;
        ssw_kick_type kick_s2;
        ssw_kick_type kick_prev;
        logic mr_s1;
        logic mr_s2;
        logic [CNT_W-1:0] mr_cnt;
        logic [CNT_W-1:0] rst_cnt;
        logic reset_n;
        logic [CNT_W-1:0] wd_cnt;
        ssw_wd_type wd_st;
        logic [CNT_W-1:0] pulse_cnt;
        logic fault_pulse_n;
        logic fault_out_n;
        logic [CNT_W-1:0] sel_cnt;
        logic sel_hold;
        logic sel_out_n;
    } ssw_state_type;

    ssw_state_type s_q; // Registered state.
    ssw_state_type s_d; // Next state.

    // Decoded helpers from synchronised inputs and the unsynchronised timeout_select.
    logic kick_edge;
    logic wd_enable;
    logic [CNT_W-1:0] tmo_cyc;
    logic mr_clear;

    ////////////////////////////////////////////////////////////////////////////////
    // Combinational decode.

    // The watchdog only runs on good main supply, outside backup and reset.
    always_comb begin
        // RULE_16 edge detect
        kick_edge = (s_q.kick_s2 != s_q.kick_prev);
        // RULE_07 RULE_18 enable
        wd_enable = s_q.cmp_s2.main_good && !s_q.cmp_s2.on_backup
            && (s_q.kick_s2 != KICK_OPEN) && s_q.reset_n;
        // RULE_03 RULE_04 timeout pick
        if (timeout_select.use_cap) begin
            tmo_cyc = CNT_W'(timeout_select.cap_nf) * CNT_W'(WD_NF_CYC);
        end else begin
            tmo_cyc = CNT_W'(WD_DEF_CYC);
        end
        // RULE_17 long press
        mr_clear = !s_q.mr_s2 && (s_q.mr_cnt >= CNT_W'(MR_N));
    end

    // Next-state logic for every part of the block.
    always_comb begin
        s_d = s_q;
        // RULE_19 two-flop sync
        s_d.cmp_s1 = cmp_in;
        s_d.cmp_s2 = s_q.cmp_s1;
        s_d.kick_s1 = kick_in;
        s_d.kick_s2 = s_q.kick_s1;
        s_d.kick_prev = s_q.kick_s2;
        s_d.mr_s1 = manual_reset_n;
        s_d.mr_s2 = s_q.mr_s1;

        // Count how long manual reset has been held low.
        if (!s_q.mr_s2) begin
            if (s_q.mr_cnt < CNT_W'(MR_N)) begin
                s_d.mr_cnt = s_q.mr_cnt + 1'b1;
            end
        end else begin
            s_d.mr_cnt = '0;
        end

        // RULE_15 RULE_05 reset stretch
        if (!s_q.cmp_s2.main_good || !s_q.mr_s2) begin
            s_d.reset_n = 1'b0;
            s_d.rst_cnt = '0;
        end else if (!s_q.reset_n) begin
            if (s_q.rst_cnt >= CNT_W'(RST_CYC - 1)) begin
                s_d.reset_n = 1'b1;
            end else begin
                s_d.rst_cnt = s_q.rst_cnt + 1'b1;
            end
        end

        // Watchdog sequencer; disabling wins over every other event.
        if (!wd_enable || mr_clear) begin
            // RULE_10 RULE_17 force high
            s_d.wd_st = WD_IDLE;
            s_d.wd_cnt = '0;
            s_d.pulse_cnt = '0;
            s_d.fault_pulse_n = 1'b1;
            s_d.fault_out_n = 1'b1;
        end else begin
            unique case (s_q.wd_st)
                WD_IDLE: begin
                    s_d.wd_st = WD_RUN;
                    s_d.wd_cnt = '0;
                end
                WD_RUN: begin
                    // RULE_16 restart
                    if (kick_edge) begin
                        s_d.wd_cnt = '0;
                    end else if (s_q.wd_cnt >= tmo_cyc - 1'b1) begin
                        // RULE_08 RULE_11 expiry
                        s_d.wd_st = WD_LEAD;
                        s_d.fault_pulse_n = 1'b0;
                        s_d.pulse_cnt = '0;
                        s_d.wd_cnt = '0;
                    end else begin
                        s_d.wd_cnt = s_q.wd_cnt + 1'b1;
                    end
                end
                WD_LEAD: begin
                    // RULE_12 lead delay
                    s_d.pulse_cnt = s_q.pulse_cnt + 1'b1;
                    if (s_q.pulse_cnt >= CNT_W'(LEAD_N - 1)) begin
                        s_d.fault_out_n = 1'b0;
                        s_d.wd_st = WD_FAULT;
                    end
                end
                WD_FAULT: begin
                    // RULE_11 pulse width
                    if (!s_q.fault_pulse_n) begin
                        s_d.pulse_cnt = s_q.pulse_cnt + 1'b1;
                        if (s_q.pulse_cnt >= CNT_W'(PULSE_N - 1)) begin
                            s_d.fault_pulse_n = 1'b1;
                        end
                    end
                    // RULE_09 kick releases
                    if (kick_edge) begin
                        s_d.fault_out_n = 1'b1;
                        s_d.fault_pulse_n = 1'b1;
                        s_d.wd_st = WD_RUN;
                        s_d.wd_cnt = '0;
                    end
                end
            endcase
        end

        // RULE_13 RULE_14 chip-select gate
        if (mr_clear) begin
            // RULE_17 gate off
            s_d.sel_hold = 1'b0;
            s_d.sel_out_n = 1'b1;
        end else if (s_q.reset_n && s_q.cmp_s2.main_good) begin
            s_d.sel_out_n = sel_in_n;
            s_d.sel_hold = !sel_in_n;
            s_d.sel_cnt = '0;
        end else if (s_q.sel_hold && !sel_in_n
            && s_q.sel_cnt < CNT_W'(SEL_N - 1)) begin
            s_d.sel_cnt = s_q.sel_cnt + 1'b1;
            s_d.sel_out_n = 1'b0;
        end else begin
            s_d.sel_hold = 1'b0;
            s_d.sel_out_n = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.

    // Reset puts the supervisor into the asserted-reset, safe-output state.
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.cmp_s1 <= 4'h0;
            s_q.kick_s1 <= KICK_OPEN;
            s_q.kick_s2 <= KICK_OPEN;
            s_q.kick_prev <= KICK_OPEN;
            s_q.wd_st <= WD_IDLE;
            s_q.fault_pulse_n <= 1'b1;
            s_q.fault_out_n <= 1'b1;
            s_q.sel_out_n <= 1'b1;
            s_q.mr_s1 <= 1'b1;
            s_q.mr_s2 <= 1'b1;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Comparator flags pass straight from the synchroniser's second stage.
    always_comb begin
        stat_out.reset_n = s_q.reset_n;
        // RULE_01 backup flag
        stat_out.backup_active = s_q.cmp_s2.on_backup;
        // RULE_02 aux flag, isolated from all other logic
        stat_out.aux_fail_flag = !s_q.cmp_s2.aux_low;
        // RULE_06 low-line warn
        stat_out.early_supply_warn = !s_q.cmp_s2.low_line;
        stat_out.fault_out_n = s_q.fault_out_n;
        stat_out.fault_pulse_n = s_q.fault_pulse_n;
        sel_out_n = s_q.sel_out_n;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    // Fault pulse goes low while the latched fault is still high.
    sequence s_pulse_fall;
        $fell(s_q.fault_pulse_n);
    endsequence
    property p_lead;
        @(posedge ref_clk) disable iff (!rstn || !clk_en)
        s_pulse_fall |-> s_q.fault_out_n;
    endproperty
    a_lead: assert property (p_lead) else $error("fault did not follow pulse"); // RULE_12

    // The latched fault falls with the pulse low, after exactly the lead count.
    sequence s_fault_fall;
        $fell(s_q.fault_out_n);
    endsequence
    property p_lead_len;
        @(posedge ref_clk) disable iff (!rstn || !clk_en)
        s_fault_fall |-> (!s_q.fault_pulse_n && s_q.pulse_cnt == CNT_W'(LEAD_N));
    endproperty
    a_lead_len: assert property (p_lead_len) else $error("lead delay wrong"); // RULE_12

    property p_open;
        @(posedge ref_clk) disable iff (!rstn || !clk_en)
        (s_q.kick_s2 == KICK_OPEN) |=> s_q.fault_out_n;
    endproperty
    a_open: assert property (p_open) else $error("fault low with kick open"); // RULE_10

    property p_rst_fault;
        @(posedge ref_clk) disable iff (!rstn || !clk_en)
        !s_q.reset_n |=> s_q.fault_out_n;
    endproperty
    a_rst_fault: assert property (p_rst_fault) else $error("fault low in reset"); // RULE_10

    property p_supply;
        @(posedge ref_clk) disable iff (!rstn || !clk_en)
        !s_q.cmp_s2.main_good |=> !s_q.reset_n;
    endproperty
    a_supply: assert property (p_supply) else $error("reset not asserted"); // RULE_15

    property p_mr;
        @(posedge ref_clk) disable iff (!rstn || !clk_en)
        !s_q.mr_s2 |=> !s_q.reset_n;
    endproperty
    a_mr: assert property (p_mr) else $error("manual reset ignored"); // RULE_05

    property p_sel;
        @(posedge ref_clk) disable iff (!rstn)
        !sel_out_n |-> ($past(s_q.reset_n) || $past(s_q.sel_hold));
    endproperty
    a_sel: assert property (p_sel) else $error("select passed in reset"); // RULE_13

    property p_release;
        @(posedge ref_clk) disable iff (!rstn || !clk_en)
        (!s_q.fault_out_n && kick_edge && wd_enable) |=> s_q.fault_out_n;
    endproperty
    a_release: assert property (p_release) else $error("fault not released"); // RULE_09

    // A switchover seen by the first sync stage shows on the flag one cycle on.
    property p_backup;
        @(posedge ref_clk) disable iff (!rstn || !clk_en)
        $rose(s_q.cmp_s1.on_backup) |=> stat_out.backup_active;
    endproperty
    a_backup: assert property (p_backup) else $error("backup flag wrong"); // RULE_01

endmodule

// ### testbench/ssw_host.sv
/*
 * Host processor model that kicks the watchdog input of the supervisor.
 * Assumes the bench changes run and float_in shortly after a rising edge.
 */
`timescale 1ns/1ps

module ssw_host (
    input wire logic ref_clk,
    input wire logic run,
    input wire logic float_in,
    output ssw_pkg::ssw_kick_type kick_in
);
    import ssw_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // The gap is far inside the shortest timeout used, and far above 100 ns.
    localparam int GAP = 100;
    // Free-running gap counter.
    int cnt = 0;
    // Driven level of the kick line.
    logic lvl = 1'b0;

    always @(posedge ref_clk) begin
        cnt <= (cnt == GAP - 1) ? 0 : cnt + 1;
        if (run && cnt == GAP - 1) begin
            lvl <= #2 ~lvl;
        end
    end

    assign kick_in = float_in ? KICK_OPEN : (lvl ? KICK_HIGH : KICK_LOW);
endmodule

// ### testbench/supply_supervisor_watchdog_tb_top.sv
/*
 * Self-checking bench for the supervisor: reset stretch, flags, select gating
 * and watchdog. The design is told of a slow clock so that all counts stay short.
 */
`timescale 1ns/1ps

module supply_supervisor_watchdog_tb_top;
    import ssw_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Stimulus and observed signals.
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic clk_en = 1'b1;
    ssw_cmp_type cmp = 4'b1000;
    ssw_tmo_type tsel = 9'h000;
    logic mr_n = 1'b1;
    logic sel_in_n = 1'b1;
    logic run = 1'b0;
    logic flt = 1'b0;
    ssw_kick_type kick;
    ssw_stat_type stat;
    logic sel_out_n;
    // Outputs as one vector, indexed by the constants below.
    wire [6:0] obs = {stat, sel_out_n};
    localparam int I_SEL = 0;
    localparam int I_PULSE = 1;
    localparam int I_FAULT = 2;
    localparam int I_RST = 6;
    // Clock rate handed to the design; the counts below follow from it.
    localparam longint F_HZ = 200000;
    localparam int STR_CYC = int'(RST_STRETCH_MS * F_HZ / 1000);
    localparam int NF_CYC = int'(WD_CAP_DMS_PER_NF * F_HZ / 10000);
    localparam int PW_CYC = int'(PULSE_MS * F_HZ / 1000);
    localparam int HOLD_CYC = int'(SEL_HOLD_US * F_HZ / 1000000);
    int n_mismatch = 0;
    int samples_checked = 0;
    int idle = 0;
    int t;
    ssw_kick_type kick_q;
    logic pulse_seen = 1'b0;

    ssw_top #(.CLK_FREQ_HZ(F_HZ)) ssw_top_i (.ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en),
        .cmp_in(cmp),
        .kick_in(kick), .timeout_select(tsel), .manual_reset_n(mr_n),
        .sel_in_n(sel_in_n), .stat_out(stat), .sel_out_n(sel_out_n));
    ssw_host ssw_host_i (.ref_clk(ref_clk), .run(run), .float_in(flt), .kick_in(kick));

    always #12.5 ref_clk = ~ref_clk;

    // Cycles since the kick line last changed, and any pulse seen at all.
    always @(posedge ref_clk) begin
        kick_q <= kick;
        idle <= (kick !== kick_q) ? 0 : idle + 1;
        if (obs[I_PULSE] === 1'b0) begin
            pulse_seen = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Waits a bounded number of cycles for one output to reach a level.
    task automatic wait_obs(input int idx, input logic v, input int lim);
        t = 0;
        while (obs[idx] !== v && t < lim) begin
            step(1);
            t++;
        end
    endtask

    task automatic conclude;
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Power-up: idle levels, then reset held for the full stretch.
    task automatic t_power_up;
        step(4);
        chk(obs[5:1], 5'h0f);
        step(STR_CYC - 30);
        chk(obs[I_RST], 1'b0);
        wait_obs(I_RST, 1'b1, 60);
        chk(obs[I_RST], 1'b1);
    endtask

    // Comparator flags follow their inputs and leave reset alone.
    task automatic t_flags;
        cmp = 4'b1111;
        step(3);
        chk(obs[5], 1'b1);
        chk(obs[4], 1'b0);
        chk(obs[I_RST], 1'b1);
        chk(obs[3], 1'b0);
        cmp = 4'b1000;
        step(3);
        chk(obs[5:3], 3'h3);
    endtask

    task automatic t_select;
        sel_in_n = 1'b0;
        step(3);
        chk(obs[I_SEL], 1'b0);
        clk_en = 1'b0;
        sel_in_n = 1'b1;
        step(3);
        chk(obs[I_SEL], 1'b0);
        clk_en = 1'b1;
        step(3);
        chk(obs[I_SEL], 1'b1);
    endtask

    // Kicks keep the watchdog quiet; silence gives pulse, lead and latch.
    task automatic t_watchdog;
        tsel = 9'h101;
        pulse_seen = 1'b0;
        run = 1'b1;
        step(2000);
        chk(pulse_seen, 1'b0);
        run = 1'b0;
        wait_obs(I_PULSE, 1'b0, NF_CYC + 100);
        chk(obs[I_PULSE], 1'b0);
        chk(idle >= NF_CYC && idle <= NF_CYC + 20, 1'b1);
        chk(obs[I_FAULT], 1'b1);
        step(1);
        chk(obs[I_FAULT], 1'b0);
        step(PW_CYC - 10);
        chk(obs[I_PULSE], 1'b0);
        wait_obs(I_PULSE, 1'b1, 20);
        chk(obs[I_PULSE], 1'b1);
        chk(obs[I_FAULT], 1'b0);
        run = 1'b1;
        wait_obs(I_FAULT, 1'b1, 1100);
        chk(obs[I_FAULT], 1'b1);
        run = 1'b0;
    endtask

    // An open kick line disables the watchdog.
    task automatic t_open;
        flt = 1'b1;
        pulse_seen = 1'b0;
        step(2000);
        chk(pulse_seen, 1'b0);
        chk(obs[I_FAULT], 1'b1);
    endtask

    // Supply loss with select active: hold for at most 15 us, then block.
    task automatic t_reset_sel;
        sel_in_n = 1'b0;
        step(3);
        cmp.main_good = 1'b0;
        wait_obs(I_RST, 1'b0, 10);
        chk(obs[I_RST], 1'b0);
        chk(obs[I_SEL], 1'b0);
        wait_obs(I_SEL, 1'b1, HOLD_CYC + 2);
        chk(obs[I_SEL], 1'b1);
        flt = 1'b0;
        pulse_seen = 1'b0;
        cmp.main_good = 1'b1;
    endtask

    // Manual reset holds reset, clears outputs, then restarts the stretch.
    task automatic t_manual;
        mr_n = 1'b0;
        step(10);
        chk(obs[I_RST], 1'b0);
        chk(obs[I_SEL], 1'b1);
        chk(obs[I_PULSE], 1'b1);
        mr_n = 1'b1;
        step(STR_CYC - 30);
        chk(obs[I_RST], 1'b0);
        chk(pulse_seen, 1'b0);
        wait_obs(I_RST, 1'b1, 60);
        chk(obs[I_RST], 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence after six cycles of reset.
    initial begin
        step(6);
        rstn = 1'b1;
        t_power_up();
        t_flags();
        t_select();
        t_watchdog();
        t_open();
        t_reset_sel();
        t_manual();
        conclude();
    end

    // Two stretches of about 40000 cycles dominate, so the limit sits just above.
    initial begin
        repeat (95000) @(posedge ref_clk);
        n_mismatch++;
        conclude();
    end
endmodule
